/* File: hdl/nva_pkg.sv */
// Purpose: Constants shared by the data store access controller.
// Assumes: A processor core reaches the registers through its I/O register space.
// Notes:   Register addresses are I/O indices chosen for this block.
package nva_pkg;
    localparam int        ADDR_W         = 10;
    localparam int        DEPTH          = 1024;
    localparam logic [5:0] OFS_CONTROL   = 6'h1c;
    localparam logic [5:0] OFS_DATA      = 6'h1d;
    localparam logic [5:0] OFS_ADDR_LOW  = 6'h1e;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h1f;
    localparam int        BIT_READ       = 0;
    localparam int        BIT_WRITE      = 1;
    localparam int        BIT_MASTER     = 2;
    localparam int        BIT_IRQ_EN     = 3;
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_DATA      = 8'h00;
    localparam logic [9:0] RST_ADDR      = 10'h000;
    localparam logic [2:0] MASTER_CYCLES = 3'h4;
    localparam logic [2:0] READ_STALL    = 3'h4;
    localparam logic [2:0] WRITE_STALL   = 3'h2;
    localparam int        OSC_KHZ        = 1000;
    localparam int        CLK_KHZ        = 10000;
    localparam int        WRITE_OSC_CYC  = 8448;
    localparam int        WRITE_CYCLES   = (WRITE_OSC_CYC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ;
endpackage

/* File: hdl/nva_array.sv */
// Purpose: Byte store of the non-volatile data space, in flip-flops.
// Assumes: One write per cycle at most; read is combinational.
// Notes:   Contents clear at reset.
`timescale 1ns/100ps
`default_nettype none
module nva_array (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    // Access
    input  wire logic [nva_pkg::ADDR_W-1:0] addr,
    input  wire logic                      writeEn,
    input  wire logic [7:0]                writeData,
    output logic      [7:0]                readData
);
    logic [7:0] mem_q [nva_pkg::DEPTH];

    // ************************************************************
    // Storage
    // ************************************************************
    generate
        for (genvar i = 0; i < nva_pkg::DEPTH; i++) begin : g_byte
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    mem_q[i] <= 8'h00;
                end else if (writeEn && addr == 10'(i)) begin
                    mem_q[i] <= writeData;
                end
            end
        end
    endgenerate

    assign readData = mem_q[addr];
endmodule
`default_nettype wire

/* File: hdl/nva_ctrl.sv */
// Purpose: Register front end and timing of the non-volatile data store.
// Assumes: One I/O access per cycle; writes and reads are one-cycle strobes.
// Notes:   The array is written when the write time ends.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [RQ1] A 1024-byte data space, each byte read or written alone.
// [RQ2] Ten-bit linear address held in high and low registers, 0 to 1023.
// [RQ3] Address bits 15 to 10 read as zero.
// [RQ4] Software loads a valid address before any access.
// [RQ5] Write stores the data register; read loads the data register.
// [RQ6] A read stalls the processor four cycles.
// [RQ7] A write stalls the processor two cycles.
// [RQ8] Write is self-timed; the write strobe bit shows busy.
// [RQ9] Writes happen only after the arming sequence.
// [RQ10] Ready interrupt enable gates the interrupt with global enable.
// [RQ11] Ready interrupt is a level while write strobe reads zero.
// [RQ12] Control bits 7 to 4 read as zero.
// [RQ13] All registers sit in the I/O register space.
// [RQ14] Software masks interrupts around the arming sequence.
// [RQ15] Master enable lasts four cycles; write strobe counts only within.
// [RQ16] Write strobe clears when the write time elapses.
// [RQ17] Read strobe fetches the byte before the next instruction.
// [RQ18] During a write, reads and address changes are ignored.
// [RQ19] Reserved bits ignore writes and stay zero.
module nva_ctrl (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // I/O register port
    input  wire logic [5:0] ioAddr,
    input  wire logic       ioWrite,
    input  wire logic       ioRead,
    input  wire logic [7:0] ioWdata,
    output logic      [7:0] ioRdata,
    // Processor status
    input  wire logic       globalIrqEnable,
    output logic            cpuStall,
    output logic            readyIrq
);
    typedef enum logic [1:0] {
        NVA_IDLE  = 2'b00,
        NVA_WRITE = 2'b01
    } nva_state_t;

    typedef struct packed {
        nva_state_t  state;
        logic [9:0]  addr;
        logic [7:0]  data;
        logic        irqEn;
        logic        master;
        logic [2:0]  masterCnt;
        logic        wStrobe;
        logic [17:0] writeCnt;
        logic [2:0]  stallCnt;
        logic [7:0]  rdata;
        logic        stall;
        logic        irq;
    } nva_regs_t;

    localparam logic [17:0] WRITE_LAST = 18'(nva_pkg::WRITE_CYCLES - 1);

    nva_regs_t  r_q;
    nva_regs_t  r_d;
    logic [7:0] arrRead;
    logic       arrWrite;
    logic [7:0] ctrlView;

    // ************************************************************
    // Byte store
    // ************************************************************
    nva_array u_array (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .addr      (r_q.addr),
        .writeEn   (arrWrite),
        .writeData (r_q.data),
        .readData  (arrRead)
    ); // RQ1

    assign arrWrite = (r_q.state == NVA_WRITE) && (r_q.writeCnt == WRITE_LAST); // RQ5

    assign ctrlView = {4'h0, r_q.irqEn, r_q.master, r_q.wStrobe, 1'b0}; // RQ12

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic busy;
        logic wrCtl;
        busy  = (r_q.state == NVA_WRITE);
        wrCtl = ioWrite && ioAddr == nva_pkg::OFS_CONTROL;
        r_d = r_q;
        if (r_q.stallCnt != 3'h0) begin
            r_d.stallCnt = r_q.stallCnt - 3'h1;
        end
        if (r_q.master) begin
            if (r_q.masterCnt == nva_pkg::MASTER_CYCLES - 3'h1) begin
                r_d.master = 1'b0; // RQ15
            end else begin
                r_d.masterCnt = r_q.masterCnt + 3'h1;
            end
        end
        if (ioWrite && ioAddr == nva_pkg::OFS_ADDR_HIGH && !busy) begin
            r_d.addr[9:8] = ioWdata[1:0]; // RQ2 RQ3 RQ18 RQ19
        end else if (ioWrite && ioAddr == nva_pkg::OFS_ADDR_LOW && !busy) begin
            r_d.addr[7:0] = ioWdata; // RQ2 RQ18
        end else if (ioWrite && ioAddr == nva_pkg::OFS_DATA) begin
            r_d.data = ioWdata;
        end else if (wrCtl) begin
            r_d.irqEn = ioWdata[nva_pkg::BIT_IRQ_EN]; // RQ10 RQ19
            if (ioWdata[nva_pkg::BIT_MASTER] && !ioWdata[nva_pkg::BIT_WRITE]) begin
                r_d.master    = 1'b1;
                r_d.masterCnt = 3'h0;
            end
            if (ioWdata[nva_pkg::BIT_WRITE] && r_q.master && !busy) begin
                r_d.state    = NVA_WRITE; // RQ9 RQ15
                r_d.wStrobe  = 1'b1; // RQ8
                r_d.writeCnt = 18'h0;
                r_d.master   = 1'b0;
                r_d.stallCnt = nva_pkg::WRITE_STALL; // RQ7
            end else if (ioWdata[nva_pkg::BIT_READ] && !busy) begin
                r_d.data     = arrRead; // RQ5 RQ17 RQ18
                r_d.stallCnt = nva_pkg::READ_STALL; // RQ6
            end
        end
        if (busy) begin
            if (r_q.writeCnt == WRITE_LAST) begin
                r_d.state   = NVA_IDLE;
                r_d.wStrobe = 1'b0; // RQ16
            end else begin
                r_d.writeCnt = r_q.writeCnt + 18'h1;
            end
        end
        r_d.stall = (r_d.stallCnt != 3'h0);
        r_d.irq   = r_d.irqEn && globalIrqEnable && !r_d.wStrobe; // RQ10 RQ11
        r_d.rdata = 8'h00;
        if (ioRead) begin
            if (ioAddr == nva_pkg::OFS_ADDR_HIGH) begin
                r_d.rdata = {6'h00, r_d.addr[9:8]}; // RQ3 RQ13
            end else if (ioAddr == nva_pkg::OFS_ADDR_LOW) begin
                r_d.rdata = r_d.addr[7:0];
            end else if (ioAddr == nva_pkg::OFS_DATA) begin
                r_d.rdata = r_d.data;
            end else if (ioAddr == nva_pkg::OFS_CONTROL) begin
                r_d.rdata = {4'h0, r_d.irqEn, r_d.master, r_d.wStrobe, 1'b0}; // RQ12
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r_q <= '{state: NVA_IDLE, addr: nva_pkg::RST_ADDR, data: nva_pkg::RST_DATA,
                     irqEn: 1'b0, master: 1'b0, masterCnt: 3'h0, wStrobe: 1'b0,
                     writeCnt: 18'h0, stallCnt: 3'h0, rdata: 8'h00, stall: 1'b0,
                     irq: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign ioRdata  = r_q.rdata;
    assign cpuStall = r_q.stall;
    assign readyIrq = r_q.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    logic wrCtl_m;
    assign wrCtl_m = ioWrite && ioAddr == nva_pkg::OFS_CONTROL;

    sequence s_arm;
        wrCtl_m && ioWdata[nva_pkg::BIT_MASTER] && !ioWdata[nva_pkg::BIT_WRITE];
    endsequence

    sequence s_read_cmd;
        wrCtl_m && ioWdata[nva_pkg::BIT_READ] && !ioWdata[nva_pkg::BIT_WRITE]
            && r_q.state == NVA_IDLE;
    endsequence

    a_master_timeout: assert property (@(posedge core_clk) disable iff (!resetn) // RQ15
        s_arm ##1 (!wrCtl_m)[*4] |=> !r_q.master)
        else $error("master enable did not time out");
    a_no_unarmed_write: assert property (@(posedge core_clk) disable iff (!resetn) // RQ9
        wrCtl_m && ioWdata[nva_pkg::BIT_WRITE] && !r_q.master && r_q.state == NVA_IDLE
            |=> !r_q.wStrobe)
        else $error("unarmed write accepted");
    a_write_needs_arm: assert property (@(posedge core_clk) disable iff (!resetn) // RQ9
        $rose(r_q.wStrobe) |-> $past(r_q.master))
        else $error("write started without arming");
    a_read_stall: assert property (@(posedge core_clk) disable iff (!resetn) // RQ6
        s_read_cmd |=> cpuStall[*4] ##1 !cpuStall)
        else $error("read stall wrong length");
    a_read_fetch: assert property (@(posedge core_clk) disable iff (!resetn) // RQ17
        s_read_cmd |=> r_q.data == $past(arrRead))
        else $error("read did not load the data register");
    a_read_ignored: assert property (@(posedge core_clk) disable iff (!resetn) // RQ18
        wrCtl_m && ioWdata[nva_pkg::BIT_READ] && r_q.state == NVA_WRITE
            |=> $stable(r_q.data))
        else $error("read accepted during write");
    a_write_stall: assert property (@(posedge core_clk) disable iff (!resetn) // RQ7
        $rose(r_q.wStrobe) |-> cpuStall ##1 cpuStall ##1 !cpuStall)
        else $error("write stall wrong length");
    a_addr_frozen: assert property (@(posedge core_clk) disable iff (!resetn) // RQ18
        r_q.state == NVA_WRITE && r_d.state == NVA_WRITE |=> $stable(r_q.addr))
        else $error("address changed during write");
    a_strobe_clear: assert property (@(posedge core_clk) disable iff (!resetn) // RQ16
        arrWrite |=> !r_q.wStrobe)
        else $error("write strobe not cleared");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!resetn) // RQ11
        readyIrq == (ctrlView[3] && !ctrlView[1] && $past(globalIrqEnable)))
        else $error("ready interrupt level wrong");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn) // RQ12
        ioRead && ioAddr == nva_pkg::OFS_CONTROL |=> ioRdata[7:4] == 4'h0)
        else $error("control reserved bits not zero");
    a_addr_high_zero: assert property (@(posedge core_clk) disable iff (!resetn) // RQ3
        ioRead && ioAddr == nva_pkg::OFS_ADDR_HIGH |=> ioRdata[7:2] == 6'h00)
        else $error("address reserved bits not zero");
endmodule
`default_nettype wire

/* File: tb/nva_cpu_model.sv */
// Purpose: Processor core model that reaches the registers through I/O space.
// Assumes: Requests change at the falling clock edge and last one cycle.
// Notes:   Released write data is inverted so a stale value is never seen.
`timescale 1ns/100ps
`default_nettype none
module nva_cpu_model (
    // Clock
    input  wire logic       core_clk,
    // I/O register port
    output logic      [5:0] ioAddr,
    output logic            ioWrite,
    output logic            ioRead,
    output logic      [7:0] ioWdata,
    input  wire logic [7:0] ioRdata,
    // Status
    output logic            globalIrqEnable
);
    initial begin
        ioAddr = 6'h00;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioWdata = 8'h00;
        globalIrqEnable = 1'b0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        ioAddr = a;
        ioWdata = d;
        ioWrite = 1'b1;
        @(negedge core_clk);
        ioWrite = 1'b0;
        ioWdata = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        ioAddr = a;
        ioRead = 1'b1;
        @(negedge core_clk);
        ioRead = 1'b0;
        d = ioRdata;
    endtask
    // Sets the global interrupt enable level.
    task automatic set_gie(input logic v);
        globalIrqEnable = v;
    endtask
    // Masks interrupts around the two control writes, one idle cycle apart.
    task automatic arm_write(input logic [7:0] irqBit);
        logic g;
        g = globalIrqEnable;
        globalIrqEnable = 1'b0;
        wr(nva_pkg::OFS_CONTROL, irqBit | 8'h04);
        wr(nva_pkg::OFS_CONTROL, irqBit | 8'h02);
        globalIrqEnable = g;
    endtask
endmodule
`default_nettype wire

/* File: tb/eeprom_access_controller_tb.sv */
// Purpose: Self-checking bench of the data store access controller.
// Assumes: One full write time fits the run.
// Notes:   Address and data are drawn from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
module eeprom_access_controller_tb;
    logic       core_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [5:0] ioAddr;
    logic       ioWrite;
    logic       ioRead;
    logic [7:0] ioWdata;
    logic [7:0] ioRdata;
    logic       globalIrqEnable;
    logic       cpuStall;
    logic       readyIrq;
    logic [7:0] r;
    logic [9:0] a;
    logic [7:0] d;
    logic [7:0] h;
    logic [7:0] l;
    int         n;
    int         error_cnt = 0;
    int         compares = 0;
    always #50 core_clk = ~core_clk;
    nva_ctrl u_dut (.core_clk(core_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata),
        .globalIrqEnable(globalIrqEnable), .cpuStall(cpuStall), .readyIrq(readyIrq));
    nva_cpu_model u_cpu (.core_clk(core_clk), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata),
        .globalIrqEnable(globalIrqEnable));
    function automatic logic [7:0] hi_exp(input logic [7:0] v);
        return {6'h00, v[1:0]};
    endfunction
    function automatic logic [7:0] ctl_exp(input logic [7:0] v);
        return {4'h0, v[3:1], 1'b0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stall_cnt(output int c);
        c = 0;
        repeat (8) begin
            if (cpuStall === 1'b1) c++;
            @(negedge core_clk);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(100 * 100000);
        error_cnt++;
        wrap_up();
    end
    initial begin
        void'($urandom(68940));
        a = 10'($urandom);
        d = 8'($urandom);
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        for (int i = 28; i < 32; i++) begin
            u_cpu.rd(6'(i), r);
            chk(r, 8'h00);
        end
        u_cpu.wr(nva_pkg::OFS_ADDR_HIGH, 8'hff);
        u_cpu.rd(nva_pkg::OFS_ADDR_HIGH, r);
        chk(r, hi_exp(8'hff));
        for (int k = 0; k < 8; k++) begin
            h = 8'($urandom);
            l = 8'($urandom);
            u_cpu.wr(nva_pkg::OFS_ADDR_HIGH, h);
            u_cpu.wr(nva_pkg::OFS_ADDR_LOW, l);
            u_cpu.rd(nva_pkg::OFS_ADDR_HIGH, r);
            chk(r, hi_exp(h));
            u_cpu.rd(nva_pkg::OFS_ADDR_LOW, r);
            chk(r, l);
        end
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'hf8);
        u_cpu.rd(nva_pkg::OFS_CONTROL, r);
        chk(r, ctl_exp(8'hf8));
        chk({7'h00, readyIrq}, 8'h00);
        u_cpu.set_gie(1'b1);
        repeat (2) @(negedge core_clk);
        chk({7'h00, readyIrq}, 8'h01);
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'h0a);
        u_cpu.rd(nva_pkg::OFS_CONTROL, r);
        chk(r, 8'h08);
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'h0c);
        repeat (5) @(negedge core_clk);
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'h0a);
        u_cpu.rd(nva_pkg::OFS_CONTROL, r);
        chk(r, 8'h08);
        u_cpu.wr(nva_pkg::OFS_ADDR_HIGH, {6'h00, a[9:8]});
        u_cpu.wr(nva_pkg::OFS_ADDR_LOW, a[7:0]);
        u_cpu.wr(nva_pkg::OFS_DATA, 8'ha5);
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'h09);
        stall_cnt(n);
        chk(8'(n), 8'h04);
        u_cpu.rd(nva_pkg::OFS_DATA, r);
        chk(r, 8'h00);
        u_cpu.wr(nva_pkg::OFS_DATA, d);
        u_cpu.arm_write(8'h08);
        stall_cnt(n);
        chk(8'(n), 8'h02);
        chk({7'h00, readyIrq}, 8'h00);
        u_cpu.rd(nva_pkg::OFS_CONTROL, r);
        chk(r, 8'h0a);
        u_cpu.wr(nva_pkg::OFS_ADDR_LOW, ~a[7:0]);
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'h09);
        u_cpu.rd(nva_pkg::OFS_ADDR_LOW, r);
        chk(r, a[7:0]);
        u_cpu.rd(nva_pkg::OFS_DATA, r);
        chk(r, d);
        n = 0;
        while (readyIrq !== 1'b1 && n < 90000) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, n > nva_pkg::WRITE_CYCLES - 60 && n < nva_pkg::WRITE_CYCLES}, 8'h01);
        u_cpu.rd(nva_pkg::OFS_CONTROL, r);
        chk(r, 8'h08);
        u_cpu.wr(nva_pkg::OFS_DATA, ~d);
        u_cpu.wr(nva_pkg::OFS_CONTROL, 8'h09);
        u_cpu.rd(nva_pkg::OFS_DATA, r);
        chk(r, d);
        wrap_up();
    end
endmodule
`default_nettype wire
